// ### core/cod_pkg.sv
// Package of opcode decoder constants, enums and carrier structs
package cod_pkg;
   // Operand field codes
   localparam logic [2:0] REG_B = 3'h0;
   localparam logic [2:0] REG_C = 3'h1;
   localparam logic [2:0] REG_D = 3'h2;
   localparam logic [2:0] REG_E = 3'h3;
   localparam logic [2:0] REG_H = 3'h4;
   localparam logic [2:0] REG_L = 3'h5;
   localparam logic [2:0] REG_MEM = 3'h6;
   localparam logic [2:0] REG_A = 3'h7;

   // Cycle counts
   localparam logic [4:0] CYC_4 = 5'h04;
   localparam logic [4:0] CYC_5 = 5'h05;
   localparam logic [4:0] CYC_6 = 5'h06;
   localparam logic [4:0] CYC_7 = 5'h07;
   localparam logic [4:0] CYC_9 = 5'h09;
   localparam logic [4:0] CYC_10 = 5'h0a;
   localparam logic [4:0] CYC_12 = 5'h0c;
   localparam logic [4:0] CYC_18 = 5'h12;

   // Fixed opcodes
   localparam logic [7:0] OP_JMP = 8'hc3;
   localparam logic [7:0] OP_CALL = 8'hcd;
   localparam logic [7:0] OP_RET = 8'hc9;
   localparam logic [7:0] OP_PAIR_PC = 8'he9;
   localparam logic [7:0] OP_RET_PE = 8'he8;
   localparam logic [7:0] OP_DAD_SP = 8'h39;
   localparam logic [7:0] OP_SUB_IMM = 8'hd6;
   localparam logic [7:0] OP_AND_IMM = 8'he6;
   localparam logic [7:0] OP_CMP_MEM = 8'hbe;
   localparam logic [7:0] OP_ROT_LC = 8'h17;
   localparam logic [7:0] OP_ROT_RC = 8'h1f;
   localparam logic [7:0] OP_IN = 8'hdb;
   localparam logic [7:0] OP_OUT = 8'hd3;
   localparam logic [7:0] OP_EI = 8'hfb;
   localparam logic [7:0] OP_DI = 8'hf3;
   localparam logic [7:0] OP_NOP = 8'h00;
   localparam logic [7:0] OP_HLT = 8'h76;
   localparam logic [7:0] OP_RIM = 8'h20;
   localparam logic [7:0] OP_SIM = 8'h30;

   // Condition codes in bits 5:3
   localparam logic [2:0] CND_PE = 3'h5;

   // Operation classes
   typedef enum logic [4:0] {
      OPC_ILLEGAL = 5'h00, OPC_JUMP, OPC_CALL, OPC_RETURN, OPC_RESTART, OPC_PAIR_PC,
      OPC_INC, OPC_DEC, OPC_INC_PAIR, OPC_DEC_PAIR, OPC_ADD, OPC_ADC, OPC_DAD,
      OPC_SUB, OPC_SBB, OPC_AND, OPC_XOR, OPC_OR, OPC_CMP, OPC_ROT_LC, OPC_ROT_RC,
      OPC_ROT_L, OPC_ROT_R, OPC_SPECIAL, OPC_IN, OPC_OUT, OPC_EI, OPC_DI, OPC_NOP,
      OPC_HLT, OPC_RIM, OPC_SIM
   } cod_op_e;

   // Flag inputs from the datapath
   typedef struct packed {
      logic sign;
      logic zero;
      logic parity;
      logic carry;
   } cod_flags_s;

   // Decoded control word
   typedef struct packed {
      logic valid;
      cod_op_e op;
      logic [2:0] dst;
      logic [2:0] src;
      logic imm;
      logic cond;
      logic taken;
      logic [2:0] vec;
      logic [4:0] cycles;
   } cod_ctl_s;

   // Decoder fsm states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_OUT = 2'b10
   } cod_st_e;
endpackage

// ### core/cod_cond.sv
// Condition flag tester for conditional branches
module cod_cond (
   // Condition field and flags
   input wire logic [2:0] cc,
   input wire cod_pkg::cod_flags_s flags,
   // Result
   output logic met
);
   // Odd codes test a set flag, even codes a clear one
   always_comb begin
      case (cc[2:1])
         2'h0: met = flags.zero;
         2'h1: met = flags.carry;
         2'h2: met = flags.parity;
         default: met = flags.sign;
      endcase
      if (!cc[0]) begin
         met = !met;
      end
   end
endmodule

// ### core/cod_decode.sv
// Opcode decoder with condition-dependent cycle counts
module cod_decode (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RSTN,
   // Fetched opcode
   input wire logic OP_VALID,
   input wire logic [7:0] OP_BYTE,
   input wire cod_pkg::cod_flags_s FLAGS,
   // Decoded control
   output cod_pkg::cod_ctl_s CTL
);
   // Registered state
   typedef struct packed {
      cod_pkg::cod_st_e st;
      cod_pkg::cod_ctl_s ctl;
   } cod_state_s;

   logic [1:0] rst_sync_r; // Reset release synchroniser
   logic rst_n; // Synchronised reset
   cod_state_s s_r; // Current state
   cod_state_s s_nxt; // Next state
   cod_pkg::cod_ctl_s d; // Combinational decode
   logic cond_met; // Condition outcome

   // Reset released through two flops
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // Condition test on bits 5:3
   cod_cond u_cond (
      .cc(OP_BYTE[5:3]),
      .flags(FLAGS),
      .met(cond_met)
   );

   // Pure decode of the opcode byte
   always_comb begin
      d = '0;
      d.valid = 1'b1;
      d.dst = OP_BYTE[5:3]; // Field codes follow the B..A map
      d.src = OP_BYTE[2:0];
      d.vec = OP_BYTE[5:3];
      d.op = cod_pkg::OPC_ILLEGAL;
      d.cycles = cod_pkg::CYC_4;
      case (OP_BYTE[7:6])
         2'h1: begin
            // Move group lies outside this decoder, except halt
            if (OP_BYTE == cod_pkg::OP_HLT) begin
               d.op = cod_pkg::OPC_HLT;
               d.cycles = cod_pkg::CYC_5;
            end
         end
         2'h2: begin
            // Arithmetic and logic on register or memory
            case (OP_BYTE[5:3])
               3'h0: d.op = cod_pkg::OPC_ADD;
               3'h1: d.op = cod_pkg::OPC_ADC;
               3'h2: d.op = cod_pkg::OPC_SUB;
               3'h3: d.op = cod_pkg::OPC_SBB;
               3'h4: d.op = cod_pkg::OPC_AND;
               3'h5: d.op = cod_pkg::OPC_XOR;
               3'h6: d.op = cod_pkg::OPC_OR;
               default: d.op = cod_pkg::OPC_CMP;
            endcase
            d.dst = cod_pkg::REG_A;
            // Memory operand costs three extra cycles
            d.cycles = (OP_BYTE[2:0] == cod_pkg::REG_MEM) ? cod_pkg::CYC_7 : cod_pkg::CYC_4;
         end
         2'h0: begin
            case (OP_BYTE[2:0])
               3'h0: begin
                  // Nop and interrupt mask access
                  if (OP_BYTE == cod_pkg::OP_NOP) d.op = cod_pkg::OPC_NOP;
                  else if (OP_BYTE == cod_pkg::OP_RIM) d.op = cod_pkg::OPC_RIM;
                  else if (OP_BYTE == cod_pkg::OP_SIM) d.op = cod_pkg::OPC_SIM;
               end
               3'h1: begin
                  // Pair add; other pair loads are elsewhere
                  if (OP_BYTE[3]) begin
                     d.op = cod_pkg::OPC_DAD;
                     d.cycles = cod_pkg::CYC_10;
                  end
               end
               3'h3: begin
                  d.op = OP_BYTE[3] ? cod_pkg::OPC_DEC_PAIR : cod_pkg::OPC_INC_PAIR;
                  d.cycles = cod_pkg::CYC_6;
               end
               3'h4, 3'h5: begin
                  d.op = OP_BYTE[0] ? cod_pkg::OPC_DEC : cod_pkg::OPC_INC;
                  d.cycles = (OP_BYTE[5:3] == cod_pkg::REG_MEM) ?
                             cod_pkg::CYC_10 : cod_pkg::CYC_4;
               end
               3'h7: begin
                  // Accumulator rotates and specials
                  case (OP_BYTE[5:3])
                     3'h0: d.op = cod_pkg::OPC_ROT_L;
                     3'h1: d.op = cod_pkg::OPC_ROT_R;
                     3'h2: d.op = cod_pkg::OPC_ROT_LC;
                     3'h3: d.op = cod_pkg::OPC_ROT_RC;
                     default: d.op = cod_pkg::OPC_SPECIAL;
                  endcase
                  d.dst = cod_pkg::REG_A;
               end
               default: d.op = cod_pkg::OPC_ILLEGAL;
            endcase
         end
         default: begin
            case (OP_BYTE[2:0])
               3'h0: begin
                  // Conditional return
                  d.op = cod_pkg::OPC_RETURN;
                  d.cond = 1'b1;
                  d.taken = cond_met;
                  d.cycles = cond_met ? cod_pkg::CYC_12 : cod_pkg::CYC_6;
               end
               3'h2: begin
                  // Conditional jump
                  d.op = cod_pkg::OPC_JUMP;
                  d.cond = 1'b1;
                  d.taken = cond_met;
                  d.imm = 1'b1;
                  d.cycles = cond_met ? cod_pkg::CYC_10 : cod_pkg::CYC_7;
               end
               3'h4: begin
                  // Conditional call
                  d.op = cod_pkg::OPC_CALL;
                  d.cond = 1'b1;
                  d.taken = cond_met;
                  d.imm = 1'b1;
                  d.cycles = cond_met ? cod_pkg::CYC_18 : cod_pkg::CYC_9;
               end
               3'h7: begin
                  d.op = cod_pkg::OPC_RESTART; // Vector in bits 5:3
                  d.taken = 1'b1;
                  d.cycles = cod_pkg::CYC_12;
               end
               3'h6: begin
                  // Immediate arithmetic and logic
                  case (OP_BYTE[5:3])
                     3'h0: d.op = cod_pkg::OPC_ADD;
                     3'h1: d.op = cod_pkg::OPC_ADC;
                     3'h2: d.op = cod_pkg::OPC_SUB;
                     3'h3: d.op = cod_pkg::OPC_SBB;
                     3'h4: d.op = cod_pkg::OPC_AND;
                     3'h5: d.op = cod_pkg::OPC_XOR;
                     3'h6: d.op = cod_pkg::OPC_OR;
                     default: d.op = cod_pkg::OPC_CMP;
                  endcase
                  d.imm = 1'b1;
                  d.dst = cod_pkg::REG_A;
                  d.cycles = cod_pkg::CYC_7;
               end
               default: begin
                  // Unconditional and miscellaneous fixed opcodes
                  case (OP_BYTE)
                     cod_pkg::OP_JMP: begin
                        d.op = cod_pkg::OPC_JUMP;
                        d.taken = 1'b1;
                        d.imm = 1'b1;
                        d.cycles = cod_pkg::CYC_10;
                     end
                     cod_pkg::OP_CALL: begin
                        d.op = cod_pkg::OPC_CALL;
                        d.taken = 1'b1;
                        d.imm = 1'b1;
                        d.cycles = cod_pkg::CYC_18;
                     end
                     cod_pkg::OP_RET: begin
                        d.op = cod_pkg::OPC_RETURN;
                        d.taken = 1'b1;
                        d.cycles = cod_pkg::CYC_10;
                     end
                     cod_pkg::OP_PAIR_PC: begin
                        d.op = cod_pkg::OPC_PAIR_PC;
                        d.taken = 1'b1;
                        d.cycles = cod_pkg::CYC_6;
                     end
                     cod_pkg::OP_IN: begin
                        d.op = cod_pkg::OPC_IN;
                        d.imm = 1'b1;
                        d.cycles = cod_pkg::CYC_10;
                     end
                     cod_pkg::OP_OUT: begin
                        d.op = cod_pkg::OPC_OUT;
                        d.imm = 1'b1;
                        d.cycles = cod_pkg::CYC_10;
                     end
                     cod_pkg::OP_EI: d.op = cod_pkg::OPC_EI;
                     cod_pkg::OP_DI: d.op = cod_pkg::OPC_DI;
                     default: d.op = cod_pkg::OPC_ILLEGAL;
                  endcase
               end
            endcase
         end
      endcase
   end

   // Next-state: latch the decode for each valid opcode
   always_comb begin
      s_nxt = s_r;
      case (s_r.st)
         cod_pkg::ST_IDLE, cod_pkg::ST_OUT: begin
            if (OP_VALID) begin
               s_nxt.ctl = d;
               s_nxt.st = cod_pkg::ST_OUT;
            end else begin
               // Valid drops so one opcode gives one pulse
               s_nxt.ctl.valid = 1'b0;
               s_nxt.st = cod_pkg::ST_IDLE;
            end
         end
         default: s_nxt = '{st: cod_pkg::ST_IDLE, ctl: '0};
      endcase
   end

   // State register
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '{st: cod_pkg::ST_IDLE, ctl: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign CTL = s_r.ctl;

   // Checks
   pe_ret_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      OP_VALID && OP_BYTE == cod_pkg::OP_RET_PE |=> CTL.op == cod_pkg::OPC_RETURN &&
      CTL.cycles == ($past(FLAGS.parity) ? cod_pkg::CYC_12 : cod_pkg::CYC_6))
      else $error("parity return wrong");
   cjump_cyc_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      OP_VALID && OP_BYTE[7:6] == 2'h3 && OP_BYTE[2:0] == 3'h2 |=>
      CTL.cycles == (CTL.taken ? cod_pkg::CYC_10 : cod_pkg::CYC_7))
      else $error("cond jump cycles wrong");
   ccall_cyc_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      OP_VALID && OP_BYTE[7:6] == 2'h3 && OP_BYTE[2:0] == 3'h4 |=>
      CTL.cycles == (CTL.taken ? cod_pkg::CYC_18 : cod_pkg::CYC_9))
      else $error("cond call cycles wrong");
   pair_pc_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      OP_VALID && OP_BYTE == cod_pkg::OP_PAIR_PC |=>
      CTL.op == cod_pkg::OPC_PAIR_PC && CTL.cycles == cod_pkg::CYC_6)
      else $error("pair to pc wrong");
   dad_sp_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      OP_VALID && OP_BYTE == cod_pkg::OP_DAD_SP |=>
      CTL.op == cod_pkg::OPC_DAD && CTL.cycles == cod_pkg::CYC_10)
      else $error("pair add wrong");
   sub_imm_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      OP_VALID && OP_BYTE == cod_pkg::OP_SUB_IMM |=>
      CTL.op == cod_pkg::OPC_SUB && CTL.imm && CTL.cycles == cod_pkg::CYC_7)
      else $error("sub immediate wrong");
   and_imm_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      OP_VALID && OP_BYTE == cod_pkg::OP_AND_IMM |=>
      CTL.op == cod_pkg::OPC_AND && CTL.imm && CTL.cycles == cod_pkg::CYC_7)
      else $error("and immediate wrong");
   cmp_mem_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      OP_VALID && OP_BYTE == cod_pkg::OP_CMP_MEM |=>
      CTL.op == cod_pkg::OPC_CMP && CTL.src == cod_pkg::REG_MEM &&
      CTL.cycles == cod_pkg::CYC_7)
      else $error("compare memory wrong");
   cmp_reg_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      OP_VALID && OP_BYTE[7:3] == 5'h17 && OP_BYTE[2:0] != cod_pkg::REG_MEM |=>
      CTL.op == cod_pkg::OPC_CMP && CTL.src == $past(OP_BYTE[2:0]) &&
      CTL.cycles == cod_pkg::CYC_4)
      else $error("compare register wrong");
   rot_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      OP_VALID && (OP_BYTE == cod_pkg::OP_ROT_LC || OP_BYTE == cod_pkg::OP_ROT_RC) |=>
      (CTL.op == cod_pkg::OPC_ROT_LC || CTL.op == cod_pkg::OPC_ROT_RC) &&
      CTL.cycles == cod_pkg::CYC_4)
      else $error("rotate wrong");
   pulse_a: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      !OP_VALID |=> !CTL.valid)
      else $error("valid not dropped");

   c_taken_c: cover property (@(posedge REF_CLK) disable iff (!rst_n) CTL.cond && CTL.taken);
   c_skip_c: cover property (@(posedge REF_CLK) disable iff (!rst_n) CTL.cond && !CTL.taken);
   c_hlt_c: cover property (@(posedge REF_CLK) disable iff (!rst_n)
      CTL.valid && CTL.op == cod_pkg::OPC_HLT);
endmodule

// ### testbench/cod_prog_mem.sv
// Behavioural program memory model that hands fetched opcodes to the decoder
module cod_prog_mem (
   // Clock
   input wire logic clk,
   // Fetched opcode toward the decoder
   output logic op_valid,
   output logic [7:0] op_byte,
   output cod_pkg::cod_flags_s flags
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle values at time zero, deliberately not all zero
   initial begin
      op_valid = 1'b0;
      op_byte = 8'h5a;
      flags = 4'ha;
   end

   // Present one byte from a falling edge through the next taking edge
   task automatic present(input logic [7:0] op, input logic [3:0] fl, input logic hold);
      op_valid = 1'b1;
      op_byte = op;
      flags = fl;
      @(posedge clk);
      @(negedge clk);
      // Hold keeps valid up so the next byte follows back to back
      if (!hold) begin
         drop();
      end
   endtask

   // Released bus shows the inverse of the last value, never a stale copy
   task automatic drop();
      op_valid = 1'b0;
      op_byte = ~op_byte;
      flags = ~flags;
   endtask
endmodule

// ### testbench/cpu_opcode_decode_timing_tb.sv
// Self-checking bench for the opcode decoder and its cycle counts
module cpu_opcode_decode_timing_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // Clock, reset and decoder hookup
   logic ref_clk;
   logic rstn;
   logic op_valid;
   logic [7:0] op_byte;
   cod_pkg::cod_flags_s flags;
   cod_pkg::cod_ctl_s ctl;
   // Bookkeeping
   int fails;
   int checks_done;

   // Program memory on the fetch side
   cod_prog_mem i_mem (.clk(ref_clk), .op_valid(op_valid), .op_byte(op_byte), .flags(flags));

   // Decoder under test
   cod_decode i_dut (
      .REF_CLK(ref_clk),
      .RSTN(rstn),
      .OP_VALID(op_valid),
      .OP_BYTE(op_byte),
      .FLAGS(flags),
      .CTL(ctl)
   );

   // 40 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // One comparison, counted
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Fetch one opcode and judge the class and count one cycle later
   task automatic expect_op(input logic [7:0] op, input logic [3:0] fl,
                            input cod_pkg::cod_op_e eop, input logic [4:0] cyc,
                            input logic hold);
      i_mem.present(op, fl, hold);
      chk(8'(ctl.valid), 8'h01);
      chk(8'(ctl.op), 8'(eop));
      chk(8'(ctl.cycles), 8'(cyc));
      // A dropped byte lets one edge pass, so valid never falls and rises in one step
      if (!hold) begin
         @(negedge ref_clk);
      end
   endtask

   // Every condition code, met and not met, for jump, call and return
   task automatic t_cond();
      int idx [4] = '{2, 0, 1, 3};
      logic [3:0] fv;
      logic v;
      logic [2:0] c;
      for (int cc = 0; cc < 8; cc++) begin
         for (int m = 0; m < 2; m++) begin
            c = 3'(cc);
            // Tested flag set to meet or miss; the others opposite to catch wrong picks
            v = (m == 1) ? c[0] : ~c[0];
            fv = {4{~v}};
            fv[idx[cc / 2]] = v;
            expect_op({2'b11, c, 3'h2}, fv, cod_pkg::OPC_JUMP,
                      (m == 1) ? cod_pkg::CYC_10 : cod_pkg::CYC_7, 1'b1);
            chk(8'(ctl.taken), 8'(m));
            expect_op({2'b11, c, 3'h4}, fv, cod_pkg::OPC_CALL,
                      (m == 1) ? cod_pkg::CYC_18 : cod_pkg::CYC_9, 1'b0);
            chk(8'(ctl.taken), 8'(m));
            expect_op({2'b11, c, 3'h0}, fv, cod_pkg::OPC_RETURN,
                      (m == 1) ? cod_pkg::CYC_12 : cod_pkg::CYC_6, 1'b0);
            chk(8'(ctl.taken), 8'(m));
         end
      end
   endtask

   // Return on even parity, then valid must fall after a single byte
   task automatic t_ret_parity();
      expect_op(cod_pkg::OP_RET_PE, 4'h2, cod_pkg::OPC_RETURN, cod_pkg::CYC_12, 1'b0);
      chk(8'(ctl.taken), 8'h01);
      chk(8'(ctl.valid), 8'h00);
      expect_op(cod_pkg::OP_RET_PE, 4'hd, cod_pkg::OPC_RETURN, cod_pkg::CYC_6, 1'b0);
      chk(8'(ctl.taken), 8'h00);
   endtask

   // Fixed opcodes, sent back to back with valid held high
   task automatic t_fixed();
      expect_op(cod_pkg::OP_PAIR_PC, 4'h0, cod_pkg::OPC_PAIR_PC, cod_pkg::CYC_6, 1'b1);
      expect_op(cod_pkg::OP_DAD_SP, 4'h0, cod_pkg::OPC_DAD, cod_pkg::CYC_10, 1'b1);
      expect_op(cod_pkg::OP_SUB_IMM, 4'h0, cod_pkg::OPC_SUB, cod_pkg::CYC_7, 1'b1);
      chk(8'(ctl.imm), 8'h01);
      expect_op(cod_pkg::OP_AND_IMM, 4'hf, cod_pkg::OPC_AND, cod_pkg::CYC_7, 1'b1);
      chk(8'(ctl.imm), 8'h01);
      expect_op(cod_pkg::OP_CMP_MEM, 4'h0, cod_pkg::OPC_CMP, cod_pkg::CYC_7, 1'b1);
      chk(8'(ctl.src), 8'(cod_pkg::REG_MEM));
      expect_op(cod_pkg::OP_ROT_LC, 4'h0, cod_pkg::OPC_ROT_LC, cod_pkg::CYC_4, 1'b1);
      expect_op(cod_pkg::OP_ROT_RC, 4'h0, cod_pkg::OPC_ROT_RC, cod_pkg::CYC_4, 1'b1);
      // Plain rotate, pair increment and an opcode outside this decoder
      expect_op(8'h07, 4'h0, cod_pkg::OPC_ROT_L, cod_pkg::CYC_4, 1'b1);
      expect_op(8'h23, 4'h0, cod_pkg::OPC_INC_PAIR, cod_pkg::CYC_6, 1'b1);
      expect_op(8'h41, 4'h0, cod_pkg::OPC_ILLEGAL, cod_pkg::CYC_4, 1'b1);
      expect_op(cod_pkg::OP_JMP, 4'h0, cod_pkg::OPC_JUMP, cod_pkg::CYC_10, 1'b1);
      expect_op(cod_pkg::OP_CALL, 4'h0, cod_pkg::OPC_CALL, cod_pkg::CYC_18, 1'b1);
      expect_op(cod_pkg::OP_RET, 4'h0, cod_pkg::OPC_RETURN, cod_pkg::CYC_10, 1'b1);
      expect_op(cod_pkg::OP_IN, 4'h0, cod_pkg::OPC_IN, cod_pkg::CYC_10, 1'b1);
      expect_op(cod_pkg::OP_OUT, 4'h0, cod_pkg::OPC_OUT, cod_pkg::CYC_10, 1'b1);
      expect_op(cod_pkg::OP_EI, 4'h0, cod_pkg::OPC_EI, cod_pkg::CYC_4, 1'b1);
      expect_op(cod_pkg::OP_DI, 4'h0, cod_pkg::OPC_DI, cod_pkg::CYC_4, 1'b1);
      expect_op(cod_pkg::OP_NOP, 4'h0, cod_pkg::OPC_NOP, cod_pkg::CYC_4, 1'b1);
      expect_op(cod_pkg::OP_HLT, 4'h0, cod_pkg::OPC_HLT, cod_pkg::CYC_5, 1'b1);
      expect_op(cod_pkg::OP_RIM, 4'h0, cod_pkg::OPC_RIM, cod_pkg::CYC_4, 1'b1);
      expect_op(cod_pkg::OP_SIM, 4'h0, cod_pkg::OPC_SIM, cod_pkg::CYC_4, 1'b0);
   endtask

   // All eight operand codes through compare, increment and restart
   task automatic t_regs();
      logic [2:0] r;
      for (int i = 0; i < 8; i++) begin
         r = 3'(i);
         // Memory operand costs more than a register one
         expect_op({5'h17, r}, 4'h0, cod_pkg::OPC_CMP,
                   (r == cod_pkg::REG_MEM) ? cod_pkg::CYC_7 : cod_pkg::CYC_4, 1'b1);
         chk(8'(ctl.src), 8'(r));
         expect_op({2'b00, r, 3'h4}, 4'h0, cod_pkg::OPC_INC,
                   (r == cod_pkg::REG_MEM) ? cod_pkg::CYC_10 : cod_pkg::CYC_4, 1'b1);
         chk(8'(ctl.dst), 8'(r));
         expect_op({2'b00, r, 3'h5}, 4'h0, cod_pkg::OPC_DEC,
                   (r == cod_pkg::REG_MEM) ? cod_pkg::CYC_10 : cod_pkg::CYC_4, 1'b1);
         chk(8'(ctl.dst), 8'(r));
         expect_op({5'h10, r}, 4'h0, cod_pkg::OPC_ADD,
                   (r == cod_pkg::REG_MEM) ? cod_pkg::CYC_7 : cod_pkg::CYC_4, 1'b1);
         chk(8'(ctl.src), 8'(r));
         expect_op({2'b11, r, 3'h7}, 4'h0, cod_pkg::OPC_RESTART, cod_pkg::CYC_12, i < 7);
         chk(8'(ctl.vec), 8'(r));
      end
   endtask

   // Reset in mid-run clears the decoded word, decoding resumes afterwards
   task automatic t_midreset();
      expect_op(cod_pkg::OP_CALL, 4'h0, cod_pkg::OPC_CALL, cod_pkg::CYC_18, 1'b0);
      rstn = 1'b0;
      @(negedge ref_clk);
      chk({ctl.valid, 2'b00, ctl.op}, 8'h00);
      chk(8'(ctl.cycles), 8'h00);
      rstn = 1'b1;
      repeat (3) @(negedge ref_clk);
      expect_op(cod_pkg::OP_NOP, 4'h0, cod_pkg::OPC_NOP, cod_pkg::CYC_4, 1'b0);
   endtask

   // Counts, verdict and end of run
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Guard against a hang
   initial begin
      repeat (100000) @(posedge ref_clk);
      fails++;
      wrap_up();
   end

   // Main sequence
   initial begin
      fails = 0;
      checks_done = 0;
      rstn = 1'b0;
      repeat (6) @(negedge ref_clk);
      chk({ctl.valid, 2'b00, ctl.op}, 8'h00);
      rstn = 1'b1;
      // First fetch no earlier than the third edge after release
      repeat (3) @(negedge ref_clk);
      t_cond();
      t_ret_parity();
      t_fixed();
      t_regs();
      t_midreset();
      wrap_up();
   end
endmodule
